// *** hw/csr_pkg.sv ***
// package: constants, register map and carrier types for the clocked serial receiver
// Behaviour
// - receive clock comes from transmitter; software sends dummy bytes to receive
// - reception starts only with receive enable set and transmit start conditions met
// - receive status goes to 1 when dummy byte written to transmit buffer
// - eight-bit words shifted in least significant bit first on shift clock
// - clean word sets receive-finished flag and, if enabled, finished interrupt; the code raises that interrupt only while the cause selects finished
// - receive DMA request when finished flag rises, suppressed after overrun
// - overrun is only error; sets overrun and error sum flags
// - cause finished plus overrun: no finished interrupt, no DMA request
// - cause error plus overrun: error interrupt if enabled, no DMA
// - next word follows only if enabled, transmit ready and no overrun
// - overrun: buffer keeps old byte, later words dropped, status stays 1
// - overrun flag cleared only by clearing receive enable
// - finished flag cleared by buffer read or enable clear; after overrun only enable
// - dummy byte is driven on transmit pin when pin selected as output
// - transmit-empty DMA request when empty flag rises while transmit enabled
// - transmit starts on enable plus buffer write; external clock also needs falling edge
// - transmit buffer writes ignored while transmit enable is 0
// - internal shift clock is clock / divider / (generator value + 1) / 2
package csr_pkg;
  // register byte offsets
  localparam logic [7:0] CSR_MODE_OFS = 8'h00;
  localparam logic [7:0] CSR_TXCTL_OFS = 8'h04;
  localparam logic [7:0] CSR_BAUD_OFS = 8'h08;
  localparam logic [7:0] CSR_IMASK_OFS = 8'h0C;
  localparam logic [7:0] CSR_RXCTL_OFS = 8'h10;
  localparam logic [7:0] CSR_TXBUF_OFS = 8'h14;
  localparam logic [7:0] CSR_RXBUF_OFS = 8'h18;
  // field positions
  localparam int CSR_MODE_CKS = 0;
  localparam int CSR_MODE_PIN = 1;
  localparam int CSR_TX_TEN = 0;
  localparam int CSR_TX_DIV_LO = 2;
  localparam int CSR_TX_EMPTY = 4;
  localparam int CSR_TX_BUSY = 5;
  localparam int CSR_IM_TXE = 0;
  localparam int CSR_IM_RX = 1;
  localparam int CSR_IM_CAUSE = 2;
  localparam int CSR_RX_REN = 0;
  localparam int CSR_RX_STAT = 1;
  localparam int CSR_RX_FIN = 2;
  localparam int CSR_RX_SUM = 3;
  localparam int CSR_RX_OVR = 4;
  // timing
  localparam int CSR_CLK_MHZ = 50;
  localparam logic [3:0] CSR_BITS = 4'h8;
  localparam logic [1:0] CSR_RESP_OK = 2'h0;
  localparam logic [1:0] CSR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CSR_DIV1, CSR_DIV8, CSR_DIV32, CSR_DIV256
  } csr_div_t;

  // software settings handed to the shifter
  typedef struct packed {
    logic ext_clk;
    logic pin_tx;
    csr_div_t div;
    logic [7:0] baud;
  } csr_cfg_t;

  // pins facing the link
  typedef struct packed {
    logic sclk;
    logic sclk_oe_n;
    logic txd;
    logic txd_oe_n;
  } csr_pins_t;

  // divider prescale in peripheral clocks
  function automatic logic [8:0] csr_prescale(csr_div_t d);
    case (d)
      CSR_DIV1: csr_prescale = 9'h001;
      CSR_DIV8: csr_prescale = 9'h008;
      CSR_DIV32: csr_prescale = 9'h020;
      default: csr_prescale = 9'h100;
    endcase
  endfunction
endpackage

// *** hw/csr_rxbuf.sv ***
// receive buffer: one byte held in a register
`timescale 1ns/100ps
module csr_rxbuf (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // load side
  input wire logic load,
  input wire logic [7:0] din,
  // read side
  output logic [7:0] dout
);
  typedef struct packed {
    logic [7:0] data;
  } csr_rb_state_t;
  csr_rb_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.data = din;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.data;
endmodule

// *** hw/csr_shifter.sv ***
// shift engine: clock generation, transmit out and receive in, one byte at a time
`timescale 1ns/100ps
module csr_shifter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire csr_pkg::csr_cfg_t cfg,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  // link inputs
  input wire logic sclk_in,
  input wire logic rxd,
  // results
  output logic done,
  output logic [7:0] rx_byte,
  output logic busy,
  output csr_pkg::csr_pins_t pins
);
  typedef enum logic [1:0] {SH_IDLE, SH_WAIT, SH_RUN} sh_st_t;
  typedef struct packed {
    sh_st_t st;
    logic [8:0] pre;
    logic [7:0] baud_rate_generator;
    logic sclk;
    logic sclk_in_d;
    logic [3:0] cnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic done;
  } sh_state_t;
  sh_state_t s_q, s_d;
  logic tick;
  logic fall;
  logic rise;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.sclk_in_d = sclk_in;
    tick = 1'b0;
    fall = 1'b0;
    rise = 1'b0;
    // internal clock: prescale, then generator value + 1, then halve
    if (s_q.st == SH_RUN && !cfg.ext_clk) begin
      if (s_q.pre + 9'h001 >= csr_pkg::csr_prescale(cfg.div)) begin
        s_d.pre = '0;
        if (s_q.baud_rate_generator == cfg.baud) begin
          s_d.baud_rate_generator = '0;
          tick = 1'b1;
        end else begin
          s_d.baud_rate_generator = s_q.baud_rate_generator + 8'h01;
        end
      end else begin
        s_d.pre = s_q.pre + 9'h001;
      end
      fall = tick && s_q.sclk;
      rise = tick && !s_q.sclk;
      if (tick) begin
        s_d.sclk = !s_q.sclk;
      end
    end else if (cfg.ext_clk) begin
      fall = s_q.sclk_in_d && !sclk_in;
      rise = !s_q.sclk_in_d && sclk_in;
    end
    case (s_q.st)
      SH_IDLE: begin
        s_d.sclk = 1'b1;
        if (start) begin
          s_d.tx = tx_byte;
          s_d.cnt = '0;
          s_d.pre = '0;
          s_d.baud_rate_generator = '0;
          // external clock waits for a falling edge before shifting
          s_d.st = cfg.ext_clk ? SH_WAIT : SH_RUN;
        end
      end
      SH_WAIT: begin
        if (fall) begin
          s_d.st = SH_RUN;
        end
      end
      SH_RUN: begin
        if (fall && s_q.cnt != 4'h0) begin
          s_d.tx = {1'b0, s_q.tx[7:1]};
        end
        if (rise) begin
          s_d.rx = {rxd, s_q.rx[7:1]};
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt + 4'h1 == csr_pkg::CSR_BITS) begin
            s_d.done = 1'b1;
            s_d.st = SH_IDLE;
          end
        end
      end
      default: s_d.st = SH_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{st: SH_IDLE, sclk: 1'b1, sclk_in_d: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign rx_byte = s_q.rx;
  assign busy = (s_q.st != SH_IDLE);
  assign pins.sclk = s_q.sclk;
  assign pins.sclk_oe_n = cfg.ext_clk;
  // dummy bytes really leave on the pin when it is a transmit output
  assign pins.txd = s_q.tx[0];
  assign pins.txd_oe_n = !cfg.pin_tx;
endmodule

// *** hw/csr_top.sv ***
// top: register slave on AXI4-Lite, transmit buffer, receive flags, interrupts and DMA requests
`timescale 1ns/100ps
module csr_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // axi write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // axi read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // link pins
  input wire logic sclk_in,
  input wire logic rxd,
  output logic sclk_out,
  output logic sclk_oe_n,
  output logic txd_out,
  output logic txd_oe_n,
  // interrupt and dma requests
  output logic irq_tx_empty,
  output logic irq_rx_done,
  output logic irq_rx_err,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  // ==========================================
  // state
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    csr_pkg::csr_cfg_t cfg;
    logic transmit_enable_bit;
    logic ren;
    logic im_txe;
    logic im_rx;
    logic cause_err;
    logic [7:0] txbuf;
    logic tx_empty;
    logic rx_stat;
    logic rx_fin;
    logic rx_sum;
    logic rx_ovr;
    logic rx_active;
    logic irq_tx;
    logic irq_rd;
    logic irq_re;
    logic dma_tx;
    logic dma_rx;
  } csr_state_t;
  csr_state_t s_q, s_d;

  logic sh_done;
  logic sh_busy;
  logic [7:0] sh_rx;
  logic [7:0] rb_data;
  csr_pkg::csr_pins_t pins;
  logic start;
  logic rb_load;
  logic wr_go;
  logic rd_go;
  logic wr_txbuf;
  logic rd_rxbuf;
  logic ren_clear;
  logic ten_rise;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  // ==========================================
  // submodules
  csr_shifter u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(s_q.cfg),
    .start(start),
    .tx_byte(s_q.txbuf),
    .sclk_in(sclk_in),
    .rxd(rxd),
    .done(sh_done),
    .rx_byte(sh_rx),
    .busy(sh_busy),
    .pins(pins)
  );

  csr_rxbuf u_rbuf (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(rb_load),
    .din(sh_rx),
    .dout(rb_data)
  );

  // ==========================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.irq_tx = 1'b0;
    s_d.irq_rd = 1'b0;
    s_d.irq_re = 1'b0;
    s_d.dma_tx = 1'b0;
    s_d.dma_rx = 1'b0;
    wr_txbuf = 1'b0;
    rd_rxbuf = 1'b0;
    ren_clear = 1'b0;
    ten_rise = 1'b0;
    rb_load = 1'b0;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    rd_val = '0;

    // bus: capture address and data in either order
    if (awvalid && !s_q.aw_full) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && !s_q.w_full) begin
      s_d.w_full = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    rd_go = arvalid && !s_q.rvalid;
    wr_val = s_q.w_data;

    // write decode, low byte lane carries all fields
    if (wr_go) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      if (s_q.w_strb[0]) begin
        case (s_q.aw_addr)
          csr_pkg::CSR_MODE_OFS: begin
            s_d.cfg.ext_clk = wr_val[csr_pkg::CSR_MODE_CKS];
            s_d.cfg.pin_tx = wr_val[csr_pkg::CSR_MODE_PIN];
          end
          csr_pkg::CSR_TXCTL_OFS: begin
            s_d.transmit_enable_bit = wr_val[csr_pkg::CSR_TX_TEN];
            ten_rise = wr_val[csr_pkg::CSR_TX_TEN] && !s_q.transmit_enable_bit;
            s_d.cfg.div = csr_pkg::csr_div_t'(wr_val[csr_pkg::CSR_TX_DIV_LO +: 2]);
          end
          csr_pkg::CSR_BAUD_OFS: s_d.cfg.baud = wr_val[7:0];
          csr_pkg::CSR_IMASK_OFS: begin
            s_d.im_txe = wr_val[csr_pkg::CSR_IM_TXE];
            s_d.im_rx = wr_val[csr_pkg::CSR_IM_RX];
            s_d.cause_err = wr_val[csr_pkg::CSR_IM_CAUSE];
          end
          csr_pkg::CSR_RXCTL_OFS: begin
            s_d.ren = wr_val[csr_pkg::CSR_RX_REN];
            ren_clear = !wr_val[csr_pkg::CSR_RX_REN];
          end
          csr_pkg::CSR_TXBUF_OFS: wr_txbuf = s_q.transmit_enable_bit;
          csr_pkg::CSR_RXBUF_OFS: wr_ok = 1'b1;
          default: wr_ok = 1'b0;
        endcase
      end else if (s_q.aw_addr > csr_pkg::CSR_RXBUF_OFS || s_q.aw_addr[1:0] != 2'h0) begin
        wr_ok = 1'b0;
      end
      s_d.bresp = wr_ok ? csr_pkg::CSR_RESP_OK : csr_pkg::CSR_RESP_SLVERR;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end

    // read decode
    case (araddr)
      csr_pkg::CSR_MODE_OFS: begin
        rd_val[csr_pkg::CSR_MODE_CKS] = s_q.cfg.ext_clk;
        rd_val[csr_pkg::CSR_MODE_PIN] = s_q.cfg.pin_tx;
      end
      csr_pkg::CSR_TXCTL_OFS: begin
        rd_val[csr_pkg::CSR_TX_TEN] = s_q.transmit_enable_bit;
        rd_val[csr_pkg::CSR_TX_DIV_LO +: 2] = s_q.cfg.div;
        rd_val[csr_pkg::CSR_TX_EMPTY] = s_q.tx_empty;
        rd_val[csr_pkg::CSR_TX_BUSY] = sh_busy;
      end
      csr_pkg::CSR_BAUD_OFS: rd_val[7:0] = s_q.cfg.baud;
      csr_pkg::CSR_IMASK_OFS: begin
        rd_val[csr_pkg::CSR_IM_TXE] = s_q.im_txe;
        rd_val[csr_pkg::CSR_IM_RX] = s_q.im_rx;
        rd_val[csr_pkg::CSR_IM_CAUSE] = s_q.cause_err;
      end
      csr_pkg::CSR_RXCTL_OFS: begin
        rd_val[csr_pkg::CSR_RX_REN] = s_q.ren;
        rd_val[csr_pkg::CSR_RX_STAT] = s_q.rx_stat;
        rd_val[csr_pkg::CSR_RX_FIN] = s_q.rx_fin;
        rd_val[csr_pkg::CSR_RX_SUM] = s_q.rx_sum;
        rd_val[csr_pkg::CSR_RX_OVR] = s_q.rx_ovr;
      end
      csr_pkg::CSR_TXBUF_OFS: rd_val[7:0] = s_q.txbuf;
      csr_pkg::CSR_RXBUF_OFS: rd_val[7:0] = rb_data;
      default: rd_ok = 1'b0;
    endcase
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_ok ? csr_pkg::CSR_RESP_OK : csr_pkg::CSR_RESP_SLVERR;
      rd_rxbuf = (araddr == csr_pkg::CSR_RXBUF_OFS);
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end

    // ==========================================
    // transmit buffer
    if (wr_txbuf) begin
      s_d.txbuf = wr_val[7:0];
      s_d.tx_empty = 1'b0;
      if (s_q.ren) begin
        s_d.rx_stat = 1'b1;
      end
    end
    if (ten_rise) begin
      s_d.irq_tx = s_q.im_txe && s_q.tx_empty;
      s_d.dma_tx = s_q.tx_empty;
    end
    // start needs enable and a full buffer; shifter owns external edge
    start = s_q.transmit_enable_bit && !s_q.tx_empty && !sh_busy;
    if (start) begin
      s_d.tx_empty = 1'b1;
      s_d.irq_tx = s_q.im_txe;
      s_d.dma_tx = 1'b1;
      // receive rides on the transmitter clock
      s_d.rx_active = s_q.ren && !s_q.rx_ovr;
    end
    if (!s_q.transmit_enable_bit) begin
      s_d.tx_empty = 1'b1;
    end

    // only clearing receive enable resets the error state
    // ahead of completion, so a word ending in this cycle still sets its flags
    if (ren_clear) begin
      s_d.rx_fin = 1'b0;
      s_d.rx_ovr = 1'b0;
      s_d.rx_sum = 1'b0;
      s_d.rx_stat = 1'b0;
      s_d.rx_active = 1'b0;
      s_d.dma_rx = 1'b0;
    end

    // ==========================================
    // receive completion
    if (sh_done && s_q.rx_active) begin
      if (s_q.rx_fin && !rd_rxbuf) begin
        // unread buffer: keep old byte, stop loading
        s_d.rx_ovr = 1'b1;
        s_d.rx_sum = 1'b1;
        s_d.irq_re = s_q.im_rx && s_q.cause_err;
        // finished request and dma both stay low here
      end else if (!s_q.rx_ovr) begin
        rb_load = 1'b1;
        s_d.rx_fin = 1'b1;
        s_d.irq_rd = s_q.im_rx && !s_q.cause_err;
        s_d.dma_rx = 1'b1;
      end
      // status falls when no further word follows and no overrun is set
      if (!(sh_busy || start || wr_txbuf || (s_q.transmit_enable_bit && !s_q.tx_empty))) begin
        s_d.rx_stat = s_q.rx_ovr || s_d.rx_ovr;
      end
      s_d.rx_active = 1'b0;
    end else if (rd_rxbuf && !s_q.rx_ovr) begin
      s_d.rx_fin = 1'b0;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{tx_empty: 1'b1, cfg: '0, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs; pin levels are registered inside the shifter, pin enables follow the mode register
  assign awready = !s_q.aw_full;
  assign wready = !s_q.w_full;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign sclk_out = pins.sclk;
  assign sclk_oe_n = pins.sclk_oe_n;
  assign txd_out = pins.txd;
  assign txd_oe_n = pins.txd_oe_n;
  assign irq_tx_empty = s_q.irq_tx;
  assign irq_rx_done = s_q.irq_rd;
  assign irq_rx_err = s_q.irq_re;
  assign dma_tx_req = s_q.dma_tx;
  assign dma_rx_req = s_q.dma_rx;
endmodule

// *** test/csr_top_asserts.sv ***
// checker: timing relations at the serial receiver top ports
`timescale 1ns/100ps
module csr_top_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // link and requests
  input wire logic sclk_out,
  input wire logic irq_tx_empty,
  input wire logic irq_rx_done,
  input wire logic irq_rx_err,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req
);
  // ==========
  // helper: rising shift clock edges modulo one word
  logic sclk_q;
  logic [2:0] rise_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q <= 1'b1;
      rise_cnt_q <= 3'h0;
    end else begin
      sclk_q <= sclk_out;
      if (sclk_out && !sclk_q) begin
        rise_cnt_q <= rise_cnt_q + 3'h1;
      end
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_word_end;
    dma_rx_req || irq_rx_err;
  endsequence
  sequence s_write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  chk_word_bits: assert property (s_word_end |-> rise_cnt_q == 3'h0)
    else $error("word ended off an eight bit boundary");
  chk_done_dma: assert property (irq_rx_done |-> dma_rx_req)
    else $error("finished interrupt without dma request");
  chk_dma_pulse: assert property (dma_rx_req |=> !dma_rx_req)
    else $error("receive dma request longer than one cycle");
  chk_irq_excl: assert property (!(irq_rx_done && irq_rx_err))
    else $error("finished and error interrupts together");
  chk_err_nodma: assert property (irq_rx_err |-> !dma_rx_req)
    else $error("dma request with overrun");
  chk_txe_dma: assert property (irq_tx_empty |-> dma_tx_req)
    else $error("transmit empty without dma request");
  chk_write_resp: assert property (s_write_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  chk_read_resp: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read data late");
endmodule

bind csr_top csr_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .sclk_out(sclk_out), .irq_tx_empty(irq_tx_empty),
  .irq_rx_done(irq_rx_done), .irq_rx_err(irq_rx_err), .dma_tx_req(dma_tx_req),
  .dma_rx_req(dma_rx_req));

// *** test/csr_peer.sv ***
// partner model: external clocked serial peripheral
`timescale 1ns/100ps
module csr_peer (
  // reset
  input wire logic rst_n,
  // link
  input wire logic sclk,
  input wire logic txd,
  output logic rxd,
  // bench side
  input wire logic [7:0] nxt,
  output logic [7:0] got,
  output int frames
);
  logic [7:0] sh;
  int n;
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    frames = 0;
    n = 0;
    sh = 8'h00;
  end
  // only the clock on sclk moves a frame; we never start one
  always @(negedge sclk) begin
    if (rst_n === 1'b1) begin
      if (n == 0) sh = nxt;
      rxd <= sh[n];
    end
  end
  always @(posedge sclk) begin
    if (rst_n !== 1'b1) begin
      n = 0;
    end else begin
      got <= {txd, got[7:1]};
      n = n + 1;
      if (n == 8) begin
        n = 0;
        frames++;
        // line released: turn it over so a stale bit cannot pass
        rxd <= #40 ~rxd;
      end
    end
  end
endmodule

// *** test/tb.sv ***
// testbench: register traffic and received words through the serial receiver
`timescale 1ns/100ps
module tb;
  logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sclk_in = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, peer_nxt = 8'h00, peer_got, a, b;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rr, wb;
  logic awready, wready, bvalid, arready, rvalid, rxd, sclk_out, txd_out;
  logic irq_rx_done, irq_rx_err, dma_rx_req, dma_tx_req, sclk_oe_n, txd_oe_n, ext_mode = 1'b0;
  int n_mismatch = 0, n_compared = 0, n_done = 0, n_err = 0, n_dma = 0, frames, i;
  int n_txdma = 0;

  csr_top u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .sclk_in(sclk_in), .rxd(rxd), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .txd_out(txd_out), .txd_oe_n(txd_oe_n), .irq_tx_empty(), .irq_rx_done(irq_rx_done),
    .irq_rx_err(irq_rx_err), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
  // the peer follows whichever side owns the shift clock
  csr_peer u_peer (.rst_n(aresetn), .sclk(ext_mode ? sclk_in : sclk_out), .txd(txd_out),
    .rxd(rxd), .nxt(peer_nxt), .got(peer_got), .frames(frames));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (irq_rx_done === 1'b1) n_done++;
    if (irq_rx_err === 1'b1) n_err++;
    if (dma_rx_req === 1'b1) n_dma++;
    if (dma_tx_req === 1'b1) n_txdma++;
  end
  // ==========
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic timeout;
    n_mismatch++;
    $display("FAIL %0t wait ran out", $time);
    wrap_up();
  endtask
  function automatic logic [31:0] rx_word(input logic ren, input logic st, input logic fin,
                                          input logic ovr);
    return {27'h0, ovr, ovr, fin, st, ren};
  endfunction
  // ==========
  // bus master
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic got;
    got = 1'b0;
    awaddr <= ad;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50 && !got; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      got = bvalid;
      wb = bresp;
    end
    bready <= 1'b0;
    if (!got) timeout();
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [7:0] ad);
    logic got;
    got = 1'b0;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50 && !got; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      got = rvalid;
      rd = rdata;
      rr = rresp;
    end
    rready <= 1'b0;
    if (!got) timeout();
    @(posedge aclk);
  endtask
  // one dummy byte out, one peer byte in; the next is loaded only once idle
  task automatic send(input logic [7:0] nx, input logic [7:0] dm);
    int f;
    f = frames;
    peer_nxt <= nx;
    wr(csr_pkg::CSR_TXBUF_OFS, {24'h0, dm});
    rd_reg(csr_pkg::CSR_RXCTL_OFS);
    chk(rd & 32'h2, 32'h2);
    // external mode: eight clock periods, line high outside the word
    for (int k = 0; k < 136 && ext_mode; k++) begin
      @(posedge aclk);
      sclk_in <= (k < 8) || !k[3];
    end
    for (int k = 0; k < 2000 && frames == f; k++) @(posedge aclk);
    if (frames == f) timeout();
    for (int k = 0; k < 20; k++) begin
      rd_reg(csr_pkg::CSR_TXCTL_OFS);
      if (rd[csr_pkg::CSR_TX_BUSY] === 1'b0) break;
    end
    if (rd[csr_pkg::CSR_TX_BUSY] !== 1'b0) timeout();
  endtask
  // ==========
  // main sequence
  initial begin
    void'($urandom(54));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(csr_pkg::CSR_RXCTL_OFS);
    chk(rd, 32'h0);
    rd_reg(8'hFC);
    chk({30'h0, rr}, {30'h0, csr_pkg::CSR_RESP_SLVERR});
    wr(8'hFC, 32'h0);
    chk({30'h0, wb}, {30'h0, csr_pkg::CSR_RESP_SLVERR});
    wr(csr_pkg::CSR_RXCTL_OFS, 32'h1);
    wr(csr_pkg::CSR_TXBUF_OFS, 32'hA5);
    chk({30'h0, wb}, {30'h0, csr_pkg::CSR_RESP_OK});
    rd_reg(csr_pkg::CSR_RXCTL_OFS);
    chk(rd, rx_word(1'b1, 1'b0, 1'b0, 1'b0));
    $display("test refusals done");
    // settings change only while idle; 50 MHz / 13 / 2 stays under 2 Mbps
    wr(csr_pkg::CSR_MODE_OFS, 32'h2);
    chk({31'h0, txd_oe_n}, 32'h0);
    wr(csr_pkg::CSR_TXCTL_OFS, 32'h1);
    wr(csr_pkg::CSR_BAUD_OFS, 32'h0C);
    wr(csr_pkg::CSR_IMASK_OFS, 32'h3);
    wr(csr_pkg::CSR_RXCTL_OFS, 32'h0, 4'h0);
    rd_reg(csr_pkg::CSR_RXCTL_OFS);
    chk(rd, rx_word(1'b1, 1'b0, 1'b0, 1'b0));
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h80 : 8'($urandom);
      b = (i == 0) ? 8'h01 : 8'($urandom);
      send(a, b);
      rd_reg(csr_pkg::CSR_RXCTL_OFS);
      chk(rd & 32'h1D, rx_word(1'b1, 1'b0, 1'b1, 1'b0));
      rd_reg(csr_pkg::CSR_RXBUF_OFS);
      chk(rd, {24'h0, a});
      chk({24'h0, peer_got}, {24'h0, b});
      rd_reg(csr_pkg::CSR_RXCTL_OFS);
      chk(rd & 32'h1D, rx_word(1'b1, 1'b0, 1'b0, 1'b0));
    end
    chk(32'(n_done), 32'd4);
    chk(32'(n_dma), 32'd4);
    $display("test clean words done");
    a = 8'($urandom);
    b = 8'($urandom);
    send(a, b);
    send(~a, b);
    rd_reg(csr_pkg::CSR_RXCTL_OFS);
    chk(rd & 32'h1D, rx_word(1'b1, 1'b0, 1'b1, 1'b1));
    rd_reg(csr_pkg::CSR_RXBUF_OFS);
    chk(rd, {24'h0, a});
    rd_reg(csr_pkg::CSR_RXCTL_OFS);
    chk(rd & 32'h1D, rx_word(1'b1, 1'b0, 1'b1, 1'b1));
    send(8'h3C, b);
    rd_reg(csr_pkg::CSR_RXCTL_OFS);
    chk(rd, rx_word(1'b1, 1'b1, 1'b1, 1'b1));
    rd_reg(csr_pkg::CSR_RXBUF_OFS);
    chk(rd, {24'h0, a});
    chk(32'(n_dma), 32'd5);
    chk(32'(n_done), 32'd5);
    wr(csr_pkg::CSR_RXCTL_OFS, 32'h0);
    rd_reg(csr_pkg::CSR_RXCTL_OFS);
    chk(rd, 32'h0);
    $display("test overrun finished cause done");
    // error cause; reception restarted after the flag was cleared
    wr(csr_pkg::CSR_IMASK_OFS, 32'h7);
    wr(csr_pkg::CSR_RXCTL_OFS, 32'h1);
    send(a, b);
    send(b, a);
    chk(32'(n_err), 32'd1);
    chk(32'(n_dma), 32'd6);
    wr(csr_pkg::CSR_RXCTL_OFS, 32'h0);
    $display("test overrun error cause done");
    // external shift clock, set up with both enables off
    wr(csr_pkg::CSR_TXCTL_OFS, 32'h0);
    wr(csr_pkg::CSR_MODE_OFS, 32'h3);
    wr(csr_pkg::CSR_TXCTL_OFS, 32'h1);
    wr(csr_pkg::CSR_RXCTL_OFS, 32'h1);
    chk({31'h0, sclk_oe_n}, 32'h1);
    ext_mode <= 1'b1;
    a = 8'($urandom);
    send(a, b);
    rd_reg(csr_pkg::CSR_RXBUF_OFS);
    chk(rd, {24'h0, a});
    chk({24'h0, peer_got}, {24'h0, b});
    chk(32'(n_dma), 32'd7);
    chk(32'(n_txdma), 32'd12);
    wr(csr_pkg::CSR_RXCTL_OFS, 32'h0);
    $display("test external clock done");
    wrap_up();
  end
endmodule
